// ===== hw/aosbi_pkg.sv
package aosbi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int RATE_BASE_HZ = 125_000;
  localparam int BASE_DIV_CYCLES = CLK_HZ / RATE_BASE_HZ;
  localparam int SYNC_LOW_CYCLES = 4;
  localparam int RATE_CNT_W = 26;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [5:0] ADDR_BID_HI = 6'h00;
  localparam logic [5:0] ADDR_BID_LO = 6'h02;
  localparam logic [5:0] ADDR_CSR = 6'h04;
  localparam logic [5:0] ADDR_SSR = 6'h08;
  localparam logic [5:0] ADDR_ICR = 6'h0C;
  localparam logic [5:0] ADDR_OCR = 6'h0E;
  localparam logic [5:0] ADDR_IRQC_IN = 6'h10;
  localparam logic [5:0] ADDR_IRQC_OUT = 6'h12;
  localparam logic [5:0] ADDR_IVEC_IN = 6'h18;
  localparam logic [5:0] ADDR_IVEC_OUT = 6'h1A;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] CSR_RST = 16'h0000;
  localparam logic [15:0] ICR_RST = 16'h0000;
  localparam logic [15:0] OCR_RST = 16'h0000;
  localparam logic [7:0] IRQC_RST = 8'h00;
  localparam logic [7:0] IVEC_RST = 8'h0F;
  // Arbitrary neutral identification value
  localparam logic [31:0] BOARD_ID_DEF = 32'h0000_1234;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CSR_OUT_EN = 14;
  localparam int CSR_STEP = 11;
  localparam int CSR_SINGLE = 10;
  localparam int CSR_SYNC = 9;
  localparam int CSR_OBUF_SEL = 8;
  localparam int CSR_SRST = 3;
  localparam int CSR_MASTER = 2;
  localparam int CSR_DIS_OSCAN = 1;
  localparam int CSR_BUF_EN = 0;
  localparam int SSR_AD_SCAN_A = 1;
  localparam int SSR_DA_RDY = 3;
  localparam int SSR_DONE = 5;
  localparam int ICR_LOOP_LSB = 11;
  localparam int OCR_BLK_LSB = 0;
  localparam int OCR_RATE_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic flag;
    logic flag_ac;
    logic ext_int;
    logic enable;
    logic enable_ac;
    logic [2:0] level;
  } aosbi_irqc_t;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } aosbi_sample_t;

  typedef enum logic [3:0] {
    SM_FREE = 4'b0001,
    SM_MASTER = 4'b0010,
    SM_SLAVE = 4'b0100,
    SM_EXT = 4'b1000
  } aosbi_sync_mode_t;

endpackage

// ===== hw/aosbi_top.sv
`timescale 1ns/1ps
module aosbi_top
  import aosbi_pkg::*;
#(
  parameter int P_BASE_DIV = BASE_DIV_CYCLES,
  parameter logic [31:0] P_BOARD_ID = BOARD_ID_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_ack,
  input wire logic i_buf_wr,
  input wire logic i_buf_rd,
  input wire logic [15:0] i_buf_addr,
  input wire logic [15:0] i_buf_wdata,
  output logic [15:0] o_buf_rdata,
  output logic o_buf_ack,
  input wire logic i_ext_sync,
  input wire logic i_shared_sync,
  output logic o_shared_sync,
  output logic o_shared_sync_oe,
  input wire logic i_in_scan_buf_a,
  output aosbi_sample_t o_dac_sample,
  output logic o_dac_valid,
  input wire logic i_dac_ready,
  output logic o_dac_enable,
  output logic [1:0] o_loop_sel,
  output logic [6:0] o_irq_n,
  output logic [6:0] o_irq_n_oe,
  input wire logic i_iack,
  input wire logic [2:0] i_iack_level,
  output logic [7:0] o_iack_vector,
  output logic o_iack_ack
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic aosbi_sync_mode_t sync_mode(input logic sync_bit, input logic master_bit);
    aosbi_sync_mode_t m;
    m = SM_FREE;
    unique case ({sync_bit, master_bit})
      2'b00: m = SM_FREE;
      2'b01: m = SM_MASTER;
      2'b10: m = SM_SLAVE;
      2'b11: m = SM_EXT;
    endcase
    return m;
  endfunction

  function automatic logic [15:0] block_last(input logic [3:0] code);
    logic [16:0] t;
    t = (17'h00001 << ({1'b0, code} + 5'h01)) - 17'h00001;
    return t[15:0];
  endfunction

  function automatic logic [RATE_CNT_W-1:0] rate_limit(input logic [3:0] code);
    logic [RATE_CNT_W-1:0] t;
    t = (RATE_CNT_W'(P_BASE_DIV) << code) - RATE_CNT_W'(1);
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic rst_all;
  logic [15:0] csr_ff;
  logic [15:0] icr_ff;
  logic [15:0] ocr_ff;
  aosbi_irqc_t irqc_ff [0:1];
  logic [7:0] ivec_ff [0:1];
  logic [15:0] obuf0 [0:65535];
  logic [15:0] obuf1 [0:65535];
  logic [2:0] ext_sync_ff;
  logic [2:0] sh_sync_ff;
  logic ext_filt_ff;
  logic sh_filt_ff;
  logic ext_or_prev_ff;
  logic sh_prev_ff;
  logic [RATE_CNT_W-1:0] rate_cnt_ff;
  logic [2:0] sync_low_ff;
  logic pend_ff;
  logic halted_ff;
  logic [15:0] oaddr_ff;
  logic rd_vld_ff;
  aosbi_sample_t rd_data_ff;
  aosbi_sample_t fifo_ff [0:1];
  logic fifo_wp_ff;
  logic fifo_rp_ff;
  logic [1:0] fifo_cnt_ff;
  logic scan_done_ff;
  logic in_buf_a_ff;
  logic [1:0] irq_pend_ff;
  aosbi_sync_mode_t mode;
  logic ext_or;
  logic ext_fall;
  logic sh_fall;
  logic rate_tick;
  logic tick;
  logic scan_on;
  logic issue;
  logic done_evt;
  logic fifo_push;
  logic fifo_pop;
  logic wr_csr;
  logic [1:0] irq_evt;
  logic [1:0] irq_req;
  logic [1:0] ack_hit;
  logic [15:0] last_addr;

  assign rst_all = i_srst | csr_ff[CSR_SRST];
  assign wr_csr = i_reg_wr && (i_reg_addr == ADDR_CSR);
  assign mode = sync_mode(csr_ff[CSR_SYNC], csr_ff[CSR_MASTER]);
  assign last_addr = block_last(ocr_ff[OCR_BLK_LSB +: 4]);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; soft reset bit clears itself through rst_all
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      csr_ff <= CSR_RST;
      icr_ff <= ICR_RST;
      ocr_ff <= OCR_RST;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_CSR) begin
        csr_ff <= i_reg_wdata;
      end
      if (i_reg_addr == ADDR_ICR) begin
        icr_ff <= i_reg_wdata;
      end
      if (i_reg_addr == ADDR_OCR) begin
        ocr_ff <= i_reg_wdata;
      end
    end
  end

  assign o_dac_enable = csr_ff[CSR_OUT_EN];
  assign o_loop_sel = icr_ff[ICR_LOOP_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Sync inputs: three stages, change taken when stages two and three agree
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      ext_sync_ff <= 3'h0;
      sh_sync_ff <= 3'h7;
      ext_filt_ff <= 1'b0;
      sh_filt_ff <= 1'b1;
      ext_or_prev_ff <= 1'b0;
      sh_prev_ff <= 1'b1;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], i_ext_sync};
      sh_sync_ff <= {sh_sync_ff[1:0], i_shared_sync};
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_filt_ff <= ext_sync_ff[2];
      end
      if (sh_sync_ff[1] == sh_sync_ff[2]) begin
        sh_filt_ff <= sh_sync_ff[2];
      end
      ext_or_prev_ff <= ext_or;
      sh_prev_ff <= sh_filt_ff;
    end
  end

  assign ext_or = ext_filt_ff | csr_ff[CSR_STEP];
  assign ext_fall = ext_or_prev_ff & ~ext_or;
  assign sh_fall = sh_prev_ff & ~sh_filt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Rate generator, one divider for both channels
  assign scan_on = ~csr_ff[CSR_DIS_OSCAN] & ~halted_ff;
  assign rate_tick = scan_on && (rate_cnt_ff == rate_limit(ocr_ff[OCR_RATE_LSB +: 4]));

  always_ff @(posedge i_sys_clk) begin
    if (rst_all || !scan_on || rate_tick) begin
      rate_cnt_ff <= '0;
    end else begin
      rate_cnt_ff <= rate_cnt_ff + RATE_CNT_W'(1);
    end
  end

  always_comb begin
    tick = 1'b0;
    unique case (mode)
      SM_FREE, SM_MASTER: tick = rate_tick;
      SM_SLAVE: tick = sh_fall;
      SM_EXT: tick = ext_fall;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared sync line: low pulse per update in master and external modes, stretched so slaves can see it
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      sync_low_ff <= 3'h0;
    end else if (tick && mode inside {SM_MASTER, SM_EXT}) begin
      sync_low_ff <= 3'(SYNC_LOW_CYCLES);
    end else if (sync_low_ff != 3'h0) begin
      sync_low_ff <= sync_low_ff - 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      o_shared_sync <= 1'b1;
      o_shared_sync_oe <= 1'b0;
    end else begin
      o_shared_sync <= (sync_low_ff == 3'h0);
      o_shared_sync_oe <= (mode == SM_MASTER) || (mode == SM_EXT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Update scheduling; one pending event, extra events collapse
  assign issue = pend_ff && scan_on && ({1'b0, fifo_cnt_ff} + {2'b00, rd_vld_ff} < 3'h2);
  assign done_evt = issue && (oaddr_ff >= last_addr);

  always_ff @(posedge i_sys_clk) begin
    if (rst_all || csr_ff[CSR_DIS_OSCAN]) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= tick | (pend_ff & ~issue);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rst_all || csr_ff[CSR_DIS_OSCAN]) begin
      oaddr_ff <= 16'h0000;
      halted_ff <= 1'b0;
    end else begin
      if (!csr_ff[CSR_SINGLE]) begin
        halted_ff <= 1'b0;
      end
      // Both modes rewind; single mode then parks at the block start
      if (done_evt) begin
        oaddr_ff <= 16'h0000;
        if (csr_ff[CSR_SINGLE]) begin
          halted_ff <= 1'b1;
        end
      end else if (issue) begin
        oaddr_ff <= oaddr_ff + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample buffers; host sees the one chosen by the select bit
  always_ff @(posedge i_sys_clk) begin
    if (i_buf_wr && csr_ff[CSR_BUF_EN] && !csr_ff[CSR_OBUF_SEL]) begin
      obuf0[i_buf_addr] <= i_buf_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_buf_wr && csr_ff[CSR_BUF_EN] && csr_ff[CSR_OBUF_SEL]) begin
      obuf1[i_buf_addr] <= i_buf_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      o_buf_rdata <= 16'h0000;
      o_buf_ack <= 1'b0;
    end else begin
      o_buf_ack <= (i_buf_rd | i_buf_wr) & csr_ff[CSR_BUF_EN];
      if (i_buf_rd && csr_ff[CSR_BUF_EN]) begin
        o_buf_rdata <= csr_ff[CSR_OBUF_SEL] ? obuf1[i_buf_addr] : obuf0[i_buf_addr];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      rd_vld_ff <= 1'b0;
      rd_data_ff <= '0;
    end else begin
      rd_vld_ff <= issue;
      if (issue) begin
        rd_data_ff.ch0 <= obuf0[oaddr_ff];
        rd_data_ff.ch1 <= obuf1[oaddr_ff];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; issue stalls while it is full, so no word is lost
  assign fifo_push = rd_vld_ff;
  assign fifo_pop = o_dac_valid & i_dac_ready;
  assign o_dac_valid = (fifo_cnt_ff != 2'h0);
  assign o_dac_sample = fifo_ff[fifo_rp_ff];

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      fifo_ff[0] <= '0;
      fifo_ff[1] <= '0;
      fifo_wp_ff <= 1'b0;
      fifo_rp_ff <= 1'b0;
      fifo_cnt_ff <= 2'h0;
    end else begin
      if (fifo_push) begin
        fifo_ff[fifo_wp_ff] <= rd_data_ff;
        fifo_wp_ff <= ~fifo_wp_ff;
      end
      if (fifo_pop) begin
        fifo_rp_ff <= ~fifo_rp_ff;
      end
      fifo_cnt_ff <= fifo_cnt_ff + {1'b0, fifo_push} - {1'b0, fifo_pop};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan-done status; a new end event beats a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      scan_done_ff <= 1'b0;
    end else begin
      scan_done_ff <= done_evt | (scan_done_ff & ~(wr_csr & i_reg_wdata[CSR_DIS_OSCAN]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupter
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      in_buf_a_ff <= 1'b0;
    end else begin
      in_buf_a_ff <= i_in_scan_buf_a;
    end
  end

  assign irq_evt[0] = in_buf_a_ff ^ i_in_scan_buf_a;
  assign irq_evt[1] = done_evt;

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      irq_req[c] = irq_pend_ff[c] & irqc_ff[c].enable & (irqc_ff[c].level != 3'h0);
    end
    ack_hit[0] = i_iack & irq_req[0] & (irqc_ff[0].level == i_iack_level);
    ack_hit[1] = i_iack & irq_req[1] & (irqc_ff[1].level == i_iack_level) & ~ack_hit[0];
    for (int k = 0; k < 7; k++) begin
      o_irq_n_oe[k] = (irq_req[0] & (irqc_ff[0].level == 3'(k + 1))) |
                      (irq_req[1] & (irqc_ff[1].level == 3'(k + 1)));
    end
  end

  assign o_irq_n = 7'h00;

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      irq_pend_ff <= 2'h0;
    end else begin
      irq_pend_ff <= irq_evt | (irq_pend_ff & ~ack_hit);
    end
  end

  // Software write wins over an acknowledge auto-clear
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      irqc_ff[0] <= IRQC_RST;
      irqc_ff[1] <= IRQC_RST;
      ivec_ff[0] <= IVEC_RST;
      ivec_ff[1] <= IVEC_RST;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ack_hit[c] && irqc_ff[c].enable_ac) begin
          irqc_ff[c].enable <= 1'b0;
        end
        if (ack_hit[c] && irqc_ff[c].flag_ac) begin
          irqc_ff[c].flag <= 1'b0;
        end
      end
      if (i_reg_wr && i_reg_addr == ADDR_IRQC_IN) begin
        irqc_ff[0] <= i_reg_wdata[7:0];
      end
      if (i_reg_wr && i_reg_addr == ADDR_IRQC_OUT) begin
        irqc_ff[1] <= i_reg_wdata[7:0];
      end
      if (i_reg_wr && i_reg_addr == ADDR_IVEC_IN) begin
        ivec_ff[0] <= i_reg_wdata[7:0];
      end
      if (i_reg_wr && i_reg_addr == ADDR_IVEC_OUT) begin
        ivec_ff[1] <= i_reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      o_iack_ack <= 1'b0;
      o_iack_vector <= 8'h00;
    end else begin
      o_iack_ack <= |ack_hit;
      if (|ack_hit) begin
        o_iack_vector <= ack_hit[1] ? ivec_ff[1] : ivec_ff[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped words read zero
  always_ff @(posedge i_sys_clk) begin
    if (rst_all) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_rd | i_reg_wr;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          ADDR_BID_HI: o_reg_rdata <= P_BOARD_ID[31:16];
          ADDR_BID_LO: o_reg_rdata <= P_BOARD_ID[15:0];
          ADDR_CSR: o_reg_rdata <= csr_ff;
          ADDR_SSR: begin
            o_reg_rdata <= 16'h0000;
            o_reg_rdata[SSR_AD_SCAN_A] <= in_buf_a_ff;
            o_reg_rdata[SSR_DA_RDY] <= scan_on & ~pend_ff;
            o_reg_rdata[SSR_DONE] <= scan_done_ff;
          end
          ADDR_ICR: o_reg_rdata <= icr_ff;
          ADDR_OCR: o_reg_rdata <= ocr_ff;
          ADDR_IRQC_IN: o_reg_rdata <= {8'h00, irqc_ff[0]};
          ADDR_IRQC_OUT: o_reg_rdata <= {8'h00, irqc_ff[1]};
          ADDR_IVEC_IN: o_reg_rdata <= {8'h00, ivec_ff[0]};
          ADDR_IVEC_OUT: o_reg_rdata <= {8'h00, ivec_ff[1]};
          default: o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ===== bench/aosbi_top_sva.sv
`timescale 1ns/1ps
module aosbi_top_sva
  import aosbi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic o_reg_ack,
  input wire logic i_buf_wr,
  input wire logic i_buf_rd,
  input wire logic o_buf_ack,
  input wire logic o_shared_sync,
  input wire logic o_shared_sync_oe,
  input wire aosbi_sample_t o_dac_sample,
  input wire logic o_dac_valid,
  input wire logic i_dac_ready,
  input wire logic o_dac_enable,
  input wire logic [1:0] o_loop_sel,
  input wire logic [6:0] o_irq_n,
  input wire logic i_iack,
  input wire logic o_iack_ack
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  logic csr_wr;
  assign csr_wr = i_reg_wr && (i_reg_addr == ADDR_CSR);
  ////////////////////////////////////////////////////////////////////////////
  sequence sync_low_s;
    (!o_shared_sync) [*4] ##1 o_shared_sync;
  endsequence
  sequence master_csr_s;
    $past(csr_wr && i_reg_wdata[CSR_MASTER]) || $past(csr_wr && i_reg_wdata[CSR_MASTER], 2);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  reg_ack_a: assert property (o_reg_ack == $past(i_reg_wr || i_reg_rd))
    else $error("register ack not one cycle after strobe");
  buf_ack_a: assert property (o_buf_ack |-> $past(i_buf_wr || i_buf_rd))
    else $error("buffer ack without strobe");
  dac_enable_a: assert property ($rose(o_dac_enable) |-> $past(csr_wr && i_reg_wdata[CSR_OUT_EN]))
    else $error("outputs enabled without control write");
  master_oe_a: assert property ($rose(o_shared_sync_oe) |-> master_csr_s)
    else $error("shared sync driven outside master mode");
  sync_pulse_a: assert property ($fell(o_shared_sync) |-> o_shared_sync_oe ##0 sync_low_s)
    else $error("shared sync pulse wrong");
  dac_hold_a: assert property (o_dac_valid && !i_dac_ready |=> o_dac_valid && $stable(o_dac_sample))
    else $error("sample dropped or changed during stall");
  loop_sel_a: assert property ($changed(o_loop_sel) |->
    $past(i_reg_wr && i_reg_addr == ADDR_ICR) && o_loop_sel == $past(i_reg_wdata[12:11]))
    else $error("loopback select changed without write");
  iack_ack_a: assert property (o_iack_ack |-> $past(i_iack))
    else $error("acknowledge answer without cycle");
  irq_low_a: assert property (o_irq_n == 7'h00)
    else $error("interrupt line driven high");
endmodule

bind aosbi_top aosbi_top_sva u_sva (.i_sys_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_ack, .i_buf_wr, .i_buf_rd, .o_buf_ack, .o_shared_sync, .o_shared_sync_oe, .o_dac_sample,
  .o_dac_valid, .i_dac_ready, .o_dac_enable, .o_loop_sel, .o_irq_n, .i_iack, .o_iack_ack);

// ===== bench/aosbi_irq_host.sv
`timescale 1ns/1ps
module aosbi_irq_host (
  input wire logic i_sys_clk,
  input wire logic [6:0] i_irq_oe,
  input wire logic i_ack,
  input wire logic [7:0] i_vector,
  output logic o_iack,
  output logic [2:0] o_level,
  output logic [7:0] o_vector,
  output logic [2:0] o_got_level,
  output int o_n_ack
);
  logic [2:0] lvl;
  initial begin
    o_iack = 1'b0;
    o_level = 3'h0;
    o_vector = 8'h00;
    o_got_level = 3'h0;
    o_n_ack = 0;
    forever begin
      @(posedge i_sys_clk);
      if (i_irq_oe != 7'h00) begin
        // Slow handler, request must stand meanwhile
        repeat (3) @(posedge i_sys_clk);
        lvl = 3'h0;
        for (int j = 0; j < 7; j++) begin
          if (i_irq_oe[j]) begin
            lvl = 3'(j + 1);
          end
        end
        o_iack <= (lvl != 3'h0);
        o_level <= lvl;
        @(posedge i_sys_clk);
        o_iack <= 1'b0;
        o_level <= 3'h0;
        @(negedge i_sys_clk);
        if (i_ack === 1'b1) begin
          o_vector = i_vector;
          o_got_level = lvl;
          o_n_ack++;
        end
      end
    end
  end
endmodule

// ===== bench/analog_output_scan_and_bus_interrupter_test.sv
`timescale 1ns/1ps
module analog_output_scan_and_bus_interrupter_test;
  import aosbi_pkg::*;
  localparam int DIV = 4;
  localparam int TMO = 20000;
  typedef struct {
    logic [5:0] a;
    logic [15:0] w;
    logic [15:0] e;
  } aosbi_row_t;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [5:0] i_reg_addr = 6'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic i_buf_wr = 1'b0;
  logic [15:0] i_buf_addr = 16'h0000;
  logic [15:0] i_buf_wdata = 16'h0000;
  logic i_ext_sync = 1'b0;
  logic i_shared_sync = 1'b1;
  logic i_in_scan_buf_a = 1'b0;
  logic i_dac_ready = 1'b1;
  logic i_iack;
  logic [2:0] i_iack_level;
  logic [15:0] o_reg_rdata;
  logic o_reg_ack, o_buf_ack, o_shared_sync, o_shared_sync_oe, o_dac_valid, o_dac_enable, o_iack_ack;
  aosbi_sample_t o_dac_sample;
  logic [1:0] o_loop_sel;
  logic [6:0] o_irq_n, o_irq_n_oe;
  logic [7:0] o_iack_vector, got_vec;
  logic [2:0] got_lvl;
  logic [15:0] d;
  logic ok;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int pops = 0;
  int idx = 0;
  int last_pop = 0;
  int intv = 0;
  int n_ack, p;
  aosbi_row_t rows [4] = '{'{ADDR_IRQC_IN, 16'hFF83, 16'h0083}, '{ADDR_IVEC_IN, 16'h12AB, 16'h00AB},
    '{ADDR_IVEC_OUT, 16'h0055, 16'h0055}, '{6'h06, 16'hFFFF, 16'h0000}};

  aosbi_top #(.P_BASE_DIV(DIV)) uut (.i_sys_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_ack, .i_buf_wr, .i_buf_rd(1'b0), .i_buf_addr, .i_buf_wdata, .o_buf_rdata(),
    .o_buf_ack, .i_ext_sync, .i_shared_sync, .o_shared_sync, .o_shared_sync_oe, .i_in_scan_buf_a,
    .o_dac_sample, .o_dac_valid, .i_dac_ready, .o_dac_enable, .o_loop_sel, .o_irq_n, .o_irq_n_oe,
    .i_iack, .i_iack_level, .o_iack_vector, .o_iack_ack);
  aosbi_irq_host u_host (.i_sys_clk, .i_irq_oe(o_irq_n_oe), .i_ack(o_iack_ack), .i_vector(o_iack_vector),
    .o_iack(i_iack), .o_level(i_iack_level), .o_vector(got_vec), .o_got_level(got_lvl), .o_n_ack(n_ack));

  always #2 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [15:0] w);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= w;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk("reg_ack", {15'h0, o_reg_ack}, 16'h0001);
    chk(n, o_reg_rdata & m, e);
  endtask
  task automatic buf_wr(input logic [15:0] a, input logic [15:0] w);
    @(posedge i_sys_clk);
    i_buf_wr <= 1'b1;
    i_buf_addr <= a;
    i_buf_wdata <= w;
    @(posedge i_sys_clk);
    i_buf_wr <= 1'b0;
    @(negedge i_sys_clk);
    ok = o_buf_ack;
  endtask
  task automatic wait_pops(input int n);
    repeat (600) begin
      if (pops >= n) break;
      @(posedge i_sys_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Sink, cycle count and hang guard share one process to avoid ordering races
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc > TMO) begin
      n_fail++;
      end_sim();
    end
    // Words drained while outputs are off hold unloaded buffer contents
    if (!i_srst && o_dac_enable === 1'b1 && o_dac_valid === 1'b1 && i_dac_ready === 1'b1) begin
      chk("dac_ch0", o_dac_sample.ch0, 16'h1000 + 16'(idx));
      chk("dac_ch1", o_dac_sample.ch1, 16'h2000 + 16'(idx));
      idx = (idx + 1) % 4;
      pops++;
      intv = cyc - last_pop;
      last_pop = cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].w);
      rd_chk("reg_rw", rows[i].a, 16'hFFFF, rows[i].e);
    end
    // Mid-run reset must restore defaults
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    rd_chk("irqc_in_rst", ADDR_IRQC_IN, 16'hFFFF, 16'h0000);
    rd_chk("irqc_out_rst", ADDR_IRQC_OUT, 16'hFFFF, 16'h0000);
    rd_chk("ivec_in_rst", ADDR_IVEC_IN, 16'hFFFF, 16'h000F);
    rd_chk("ivec_out_rst", ADDR_IVEC_OUT, 16'hFFFF, 16'h000F);
    rd_chk("csr_rst", ADDR_CSR, 16'hFFFF, 16'h0000);
    buf_wr(16'h0000, 16'hDEAD);
    chk("buf_locked", {15'h0, ok}, 16'h0000);
    // Scan held off while loading, so it restarts at address 0
    for (int s = 0; s < 2; s++) begin
      reg_wr(ADDR_CSR, 16'h0003 | 16'(s << CSR_OBUF_SEL));
      for (int i = 0; i < 4; i++) begin
        buf_wr(16'(i), (16'h1000 << s) + 16'(i));
        chk("buf_ack", {15'h0, ok}, 16'h0001);
      end
    end
    reg_wr(ADDR_OCR, 16'h0001);
    reg_wr(ADDR_IVEC_OUT, 16'h005A);
    // Bit 5 kept zero by host
    reg_wr(ADDR_IRQC_OUT, 16'h00DA);
    chk("dac_off", {15'h0, o_dac_enable}, 16'h0000);
    reg_wr(ADDR_CSR, 16'h4001);
    @(negedge i_sys_clk);
    chk("dac_on", {15'h0, o_dac_enable}, 16'h0001);
    wait_pops(8);
    chk("rate0", 16'(intv), 16'(DIV));
    chk("free_oe", {15'h0, o_shared_sync_oe}, 16'h0000);
    reg_wr(ADDR_OCR, 16'h0021);
    wait_pops(pops + 4);
    chk("rate2", 16'(intv), 16'(DIV << 2));
    chk("ch1_vec", {8'h00, got_vec}, 16'h005A);
    chk("ch1_lvl", {13'h0, got_lvl}, 16'h0002);
    chk("ch1_once", 16'(n_ack), 16'h0001);
    rd_chk("irqc_ac", ADDR_IRQC_OUT, 16'hFFFF, 16'h004A);
    rd_chk("done_set", ADDR_SSR, 16'h0020, 16'h0020);
    reg_wr(ADDR_CSR, 16'h4003);
    rd_chk("done_clr", ADDR_SSR, 16'h0020, 16'h0000);
    reg_wr(ADDR_OCR, 16'h0001);
    idx = 0;
    reg_wr(ADDR_CSR, 16'h4001);
    wait_pops(pops + 3);
    // Stall longer than the buffer depth; ticks collapse, no word lost
    i_dac_ready <= 1'b0;
    repeat (40) @(posedge i_sys_clk);
    chk("stall_valid", {15'h0, o_dac_valid}, 16'h0001);
    i_dac_ready <= 1'b1;
    reg_wr(ADDR_CSR, 16'h4401);
    repeat (60) @(posedge i_sys_clk);
    p = pops;
    repeat (60) @(posedge i_sys_clk);
    chk("single_halt", 16'(pops - p), 16'h0000);
    chk("single_end", 16'(idx), 16'h0000);
    reg_wr(ADDR_CSR, 16'h4205);
    repeat (20) @(posedge i_sys_clk);
    chk("ext_oe", {15'h0, o_shared_sync_oe}, 16'h0001);
    p = pops;
    // Pulse spacing well below the scaled maximum event rate
    repeat (3) begin
      i_ext_sync <= 1'b1;
      repeat (12) @(posedge i_sys_clk);
      i_ext_sync <= 1'b0;
      repeat (12) @(posedge i_sys_clk);
    end
    chk("ext_pops", 16'(pops - p), 16'h0003);
    reg_wr(ADDR_CSR, 16'h4A05);
    reg_wr(ADDR_CSR, 16'h4205);
    repeat (20) @(posedge i_sys_clk);
    chk("step_pop", 16'(pops - p), 16'h0004);
    reg_wr(ADDR_CSR, 16'h4201);
    repeat (20) @(posedge i_sys_clk);
    chk("slave_oe", {15'h0, o_shared_sync_oe}, 16'h0000);
    p = pops;
    repeat (2) begin
      i_shared_sync <= 1'b0;
      repeat (12) @(posedge i_sys_clk);
      i_shared_sync <= 1'b1;
      repeat (12) @(posedge i_sys_clk);
    end
    chk("slave_pops", 16'(pops - p), 16'h0002);
    for (int c = 0; c < 4; c++) begin
      reg_wr(ADDR_ICR, 16'(c << ICR_LOOP_LSB));
      @(negedge i_sys_clk);
      chk("loop_sel", {14'h0, o_loop_sel}, 16'(c));
    end
    reg_wr(ADDR_IVEC_IN, 16'h003C);
    reg_wr(ADDR_IRQC_IN, 16'h0013);
    p = n_ack;
    for (int t = 0; t < 2; t++) begin
      i_in_scan_buf_a <= ~i_in_scan_buf_a;
      repeat (20) @(posedge i_sys_clk);
      chk("ch0_ack", 16'(n_ack - p), 16'(t + 1));
      chk("ch0_vec", {8'h00, got_vec}, 16'h003C);
      chk("ch0_lvl", {13'h0, got_lvl}, 16'h0003);
    end
    reg_wr(ADDR_IRQC_IN, 16'h0010);
    i_in_scan_buf_a <= ~i_in_scan_buf_a;
    repeat (20) @(posedge i_sys_clk);
    chk("lvl0_quiet", 16'(n_ack - p), 16'h0002);
    end_sim();
  end
endmodule
